// file: rtl/tcr_general_regs.v
// The plain strobed port is this design's own decision.
`include "tcr_defs.vh"

module tcr_general_regs #(
    parameter [15:0] HW_ID = 16'h0a5a, // arbitrary value
    parameter [5:0] FW_PATCH = 6'h00,
    parameter [4:0] FW_MINOR = 5'h00,
    parameter [4:0] FW_MAJOR = 5'h01,
    parameter [31:0] SERIAL = 32'h00000000,
    parameter [15:0] LENS_RESET = 16'h0000
) (
    input wire clk_i,
    input wire rst_i,
    input wire [15:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [15:0] rdata_o,
    input wire cal_busy_i,
    input wire illum_temp_err_i,
    input wire sensor_temp_err_i,
    input wire base_temp_err_i,
    input wire sensor_module_err_i,
    input wire illum_overtemp_i,
    input wire factory_map_i,
    input wire calib_missing_i,
    input wire fw_restored_i,
    input wire poe_limited_i,
    input wire illum_module_err_i,
    input wire color_stream_err_i,
    output reg video_mode_o,
    output reg manual_trigger_o,
    output reg snapshot_trigger_o,
    output reg [7:0] format_o,
    output reg [15:0] exposure_o,
    output reg [15:0] mod_freq_o,
    output reg [15:0] frame_rate_o,
    output reg [15:0] lens_o,
    output reg flash_unlock_o,
    output reg test_unlock_o
);

    // snap a requested frequency to the largest predefined step not above it, or to the lowest step if it is below them all
    function [15:0] tcr_snap_freq;
        input [15:0] req;
        integer i;
        reg [15:0] cand;
        begin
            tcr_snap_freq = `TCR_MODFREQ_BASE;
            for (i = 0; i < `TCR_MODFREQ_NUM; i = i + 1) begin
                cand = `TCR_MODFREQ_BASE + i[15:0] * `TCR_MODFREQ_STEP;
                if (req >= cand) begin
                    tcr_snap_freq = cand;
                end
            end
        end
    endfunction

    // clamp an exposure request into the accepted window
    function [15:0] tcr_clamp_exp;
        input [15:0] req;
        begin
            if (req < `TCR_EXPOSURE_MIN) begin
                tcr_clamp_exp = `TCR_EXPOSURE_MIN;
            end else if (req > `TCR_EXPOSURE_MAX) begin
                tcr_clamp_exp = `TCR_EXPOSURE_MAX;
            end else begin
                tcr_clamp_exp = req;
            end
        end
    endfunction

    // register write decode, shared by all writable registers
    function tcr_hit;
        input [15:0] a;
        input [15:0] target;
        begin
            tcr_hit = (a == target);
        end
    endfunction

    // reset word of the control register, so its mode bit can be picked out by position
    localparam [15:0] OPCTL_RST = `TCR_RST_OPCTL;

    reg clear_reg;
    reg [15:0] status_reg;
    reg [15:0] unlock_reg;
    reg [15:0] status_next;
    reg [15:0] read_next;
    wire wr_opctl;

    assign wr_opctl = wr_i && tcr_hit(addr_i, `TCR_ADDR_OPCTL);

    // acquisition mode; only bit 0 of the control word is stored
    always @(posedge clk_i) begin
        if (rst_i) begin
            video_mode_o <= OPCTL_RST[`TCR_OPCTL_VIDEO];
        end else if (wr_opctl) begin
            video_mode_o <= wdata_i[`TCR_OPCTL_VIDEO];
        end
    end

    // self-clearing action bits become one-cycle pulses, never stored
    always @(posedge clk_i) begin
        if (rst_i) begin
            manual_trigger_o <= 1'b0;
            snapshot_trigger_o <= 1'b0;
            clear_reg <= 1'b0;
        end else begin
            manual_trigger_o <= wr_opctl && wdata_i[`TCR_OPCTL_MANTRIG];
            snapshot_trigger_o <= wr_opctl && wdata_i[`TCR_OPCTL_SNAP];
            clear_reg <= wr_opctl && wdata_i[`TCR_OPCTL_CLRSTAT];
        end
    end

    // status next value: live flags follow their sources, sticky flags hold
    always @* begin
        status_next = 16'h0000;
        status_next[`TCR_ST_CALBUSY] = cal_busy_i;
        status_next[`TCR_ST_ILLTEMP] = illum_temp_err_i;
        status_next[`TCR_ST_SENTEMP] = sensor_temp_err_i;
        status_next[`TCR_ST_BASETEMP] = base_temp_err_i;
        status_next[`TCR_ST_OVERTEMP] = illum_overtemp_i;
        status_next[`TCR_ST_SENERR] = sensor_module_err_i;
        status_next[`TCR_ST_FACTORY] = factory_map_i;
        // sticky flags; an event in the clear cycle wins over the clear
        // calibration, firmware, PoE limit, illumination module and color stream flags
        status_next[`TCR_ST_CALMISS] = calib_missing_i |
            (status_reg[`TCR_ST_CALMISS] & ~clear_reg);
        status_next[`TCR_ST_FWREST] = fw_restored_i |
            (status_reg[`TCR_ST_FWREST] & ~clear_reg);
        status_next[`TCR_ST_POELIM] = poe_limited_i |
            (status_reg[`TCR_ST_POELIM] & ~clear_reg);
        status_next[`TCR_ST_ILLERR] = illum_module_err_i |
            (status_reg[`TCR_ST_ILLERR] & ~clear_reg);
        status_next[`TCR_ST_COLERR] = color_stream_err_i |
            (status_reg[`TCR_ST_COLERR] & ~clear_reg);
    end

    // status word; writes to its address never reach it, only the clear bit of the control word acts on it
    always @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= `TCR_RST_STATUS;
        end else begin
            status_reg <= status_next;
        end
    end

    // stream content selector, only the documented field is kept
    always @(posedge clk_i) begin
        if (rst_i) begin
            format_o <= `TCR_RST_FORMAT;
        end else if (wr_i && tcr_hit(addr_i, `TCR_ADDR_FORMAT)) begin
            format_o <= wdata_i[`TCR_FMT_MSB:`TCR_FMT_LSB];
        end
    end

    // exposure is clamped on write so the sensor never sees an illegal time
    always @(posedge clk_i) begin
        if (rst_i) begin
            exposure_o <= `TCR_RST_EXPOSURE;
        end else if (wr_i && tcr_hit(addr_i, `TCR_ADDR_EXPOSURE)) begin
            exposure_o <= tcr_clamp_exp(wdata_i);
        end
    end

    // inexact frequencies snap to a predefined step, and reads return the step
    always @(posedge clk_i) begin
        if (rst_i) begin
            mod_freq_o <= `TCR_RST_MODFREQ;
        end else if (wr_i && tcr_hit(addr_i, `TCR_ADDR_MODFREQ)) begin
            mod_freq_o <= tcr_snap_freq(wdata_i);
        end
    end

    // frame rate is stored as written
    always @(posedge clk_i) begin
        if (rst_i) begin
            frame_rate_o <= `TCR_RST_RATE;
        end else if (wr_i && tcr_hit(addr_i, `TCR_ADDR_RATE)) begin
            frame_rate_o <= wdata_i;
        end
    end

    // lens identifier, plain read/write storage
    always @(posedge clk_i) begin
        if (rst_i) begin
            lens_o <= LENS_RESET;
        end else if (wr_i && tcr_hit(addr_i, `TCR_ADDR_LENS)) begin
            lens_o <= wdata_i;
        end
    end

    // unlock key and its decoded enables; the enables lag the key by one cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            unlock_reg <= `TCR_RST_UNLOCK;
        end else if (wr_i && tcr_hit(addr_i, `TCR_ADDR_UNLOCK)) begin
            unlock_reg <= wdata_i;
        end
    end

    // protected functions downstream must check these before acting
    always @(posedge clk_i) begin
        if (rst_i) begin
            flash_unlock_o <= 1'b0;
            test_unlock_o <= 1'b0;
        end else begin
            flash_unlock_o <= (unlock_reg == `TCR_KEY_FLASH);
            test_unlock_o <= (unlock_reg == `TCR_KEY_TEST);
        end
    end

    // read multiplexer; unmapped addresses and reserved bits read zero
    always @* begin
        read_next = 16'h0000;
        case (addr_i)
            `TCR_ADDR_OPCTL: begin
                read_next[`TCR_OPCTL_VIDEO] = video_mode_o;
            end
            `TCR_ADDR_STATUS: begin
                read_next = status_reg;
            end
            `TCR_ADDR_FORMAT: begin
                read_next[`TCR_FMT_MSB:`TCR_FMT_LSB] = format_o;
            end
            `TCR_ADDR_EXPOSURE: begin
                read_next = exposure_o;
            end
            `TCR_ADDR_HWID: begin
                read_next = HW_ID;
            end
            `TCR_ADDR_MODFREQ: begin
                read_next = mod_freq_o;
            end
            `TCR_ADDR_RATE: begin
                read_next = frame_rate_o;
            end
            `TCR_ADDR_LENS: begin
                read_next = lens_o;
            end
            `TCR_ADDR_SER_LO: begin
                read_next = SERIAL[15:0];
            end
            `TCR_ADDR_SER_HI: begin
                read_next = SERIAL[31:16];
            end
            `TCR_ADDR_UNLOCK: begin
                read_next = unlock_reg;
            end
            `TCR_ADDR_FWREV: begin
                read_next = {FW_MAJOR, FW_MINOR, FW_PATCH};
            end
            default: begin
                read_next = 16'h0000;
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            rdata_o <= read_next;
        end else begin
            rdata_o <= 16'h0000;
        end
    end

endmodule // tcr_general_regs

// file: rtl/tcr_defs.vh
`ifndef TCR_DEFS_VH
`define TCR_DEFS_VH

// register offsets
`define TCR_ADDR_OPCTL 16'h0001
`define TCR_ADDR_STATUS 16'h0003
`define TCR_ADDR_FORMAT 16'h0004
`define TCR_ADDR_EXPOSURE 16'h0005
`define TCR_ADDR_HWID 16'h0006
`define TCR_ADDR_MODFREQ 16'h0009
`define TCR_ADDR_RATE 16'h000a
`define TCR_ADDR_LENS 16'h000b
`define TCR_ADDR_SER_LO 16'h000c
`define TCR_ADDR_SER_HI 16'h000d
`define TCR_ADDR_UNLOCK 16'h0022
`define TCR_ADDR_FWREV 16'h8000

// operating_control fields
`define TCR_OPCTL_VIDEO 0
`define TCR_OPCTL_MANTRIG 4
`define TCR_OPCTL_CLRSTAT 6
`define TCR_OPCTL_SNAP 11

// condition_flags fields
`define TCR_ST_CALBUSY 2
`define TCR_ST_ILLTEMP 3
`define TCR_ST_SENTEMP 4
`define TCR_ST_CALMISS 5
`define TCR_ST_FACTORY 6
`define TCR_ST_FWREST 8
`define TCR_ST_OVERTEMP 9
`define TCR_ST_POELIM 10
`define TCR_ST_ILLERR 11
`define TCR_ST_COLERR 13
`define TCR_ST_BASETEMP 14
`define TCR_ST_SENERR 15

// output_format_select field
`define TCR_FMT_LSB 3
`define TCR_FMT_MSB 10

// fw_revision fields
`define TCR_FW_PATCH_W 6
`define TCR_FW_MINOR_W 5
`define TCR_FW_MAJOR_W 5

// reset values and limits
`define TCR_RST_OPCTL 16'h0001
`define TCR_RST_STATUS 16'h0040
`define TCR_RST_FORMAT 8'h00
`define TCR_RST_EXPOSURE 16'h05dc
`define TCR_EXPOSURE_MIN 16'h0001
`define TCR_EXPOSURE_MAX 16'h05dc
`define TCR_RST_MODFREQ 16'h07d0
`define TCR_MODFREQ_BASE 16'h04b0
`define TCR_MODFREQ_STEP 16'h0190
`define TCR_MODFREQ_NUM 8
`define TCR_RST_RATE 16'h0028
`define TCR_RST_UNLOCK 16'h0000
`define TCR_KEY_FLASH 16'h4877
`define TCR_KEY_TEST 16'h5e6b

`endif

// file: bench/tcr_regs_monitor.sv
// watches the register port and the mode, trigger, format, exposure and unlock outputs of the bank
module tcr_regs_mon (
    input wire clk_i,
    input wire rst_i,
    input wire [15:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [15:0] rdata_o,
    input wire video_mode_o,
    input wire manual_trigger_o,
    input wire snapshot_trigger_o,
    input wire [7:0] format_o,
    input wire [15:0] exposure_o,
    input wire flash_unlock_o,
    input wire test_unlock_o
);
    // one clock domain, so clocking and reset are given once
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire ctl_wr = wr_i && addr_i == 16'h0001;
    // key write, then no other key write before the level shows
    sequence s_flash_key;
        wr_i && addr_i == 16'h0022 && wdata_i == 16'h4877;
    endsequence
    sequence s_key_kept;
        !(wr_i && addr_i == 16'h0022);
    endsequence
    AST_TRIG_CAUSE: assert property (manual_trigger_o == $past(ctl_wr && wdata_i[4]))
        else $error("manual trigger does not match control write");
    AST_SNAP_CAUSE: assert property (snapshot_trigger_o == $past(ctl_wr && wdata_i[11]))
        else $error("snapshot trigger does not match control write");
    AST_VIDEO_SET: assert property (ctl_wr |=> video_mode_o == $past(wdata_i[0]))
        else $error("video mode not taken from bit 0");
    AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data not zero outside read answer");
    AST_RD_CTL: assert property (rd_i && addr_i == 16'h0001 |=> rdata_o == {15'h0000, video_mode_o})
        else $error("control readback shows more than the mode bit");
    AST_EXPO_CLAMP: assert property (wr_i && addr_i == 16'h0005 |=> exposure_o == ($past(wdata_i) == 16'h0000 ?
        16'h0001 : ($past(wdata_i) > 16'h05dc ? 16'h05dc : $past(wdata_i))))
        else $error("exposure not held within range");
    AST_FMT_FIELD: assert property (wr_i && addr_i == 16'h0004 |=> format_o == $past(wdata_i[10:3]))
        else $error("format field not taken from bits 3 to 10");
    AST_FLASH_KEY: assert property (s_flash_key ##1 s_key_kept |=> flash_unlock_o && !test_unlock_o)
        else $error("flash unlock level not raised");
endmodule // tcr_regs_mon

bind tcr_general_regs tcr_regs_mon u_mon (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .video_mode_o(video_mode_o), .manual_trigger_o(manual_trigger_o),
    .snapshot_trigger_o(snapshot_trigger_o), .format_o(format_o), .exposure_o(exposure_o),
    .flash_unlock_o(flash_unlock_o), .test_unlock_o(test_unlock_o));

// file: bench/tcr_general_regs_tb_top.sv
module tcr_general_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [31:0] SER = 32'h3c5a9e21;
    localparam [15:0] HWID = 16'h1b2c; // arbitrary value
    logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic [15:0] addr_i = 16'h0000, wdata_i = 16'h0000, v;
    logic [11:0] st = 12'h040;
    wire [15:0] rdata_o, exposure_o, mod_freq_o, frame_rate_o, lens_o;
    wire [7:0] format_o;
    wire video_mode_o, manual_trigger_o, snapshot_trigger_o, flash_unlock_o, test_unlock_o;
    int mismatches = 0, check_count = 0, cyc = 0;
    logic [15:0] ra [13] = '{16'h0001, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0009, 16'h000a, 16'h000b,
        16'h000c, 16'h000d, 16'h8000, 16'h0022, 16'h0002};
    logic [15:0] rv [13] = '{16'h0001, 16'h0040, 16'h0000, 16'h05dc, HWID, 16'h07d0, 16'h0028, 16'h0007,
        SER[15:0], SER[31:16], {5'h03, 5'h0a, 6'h15}, 16'h0000, 16'h0000};
    logic [15:0] ro [6] = '{16'h0003, 16'h0006, 16'h000c, 16'h000d, 16'h8000, 16'h0002};
    logic [7:0] fc [8] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h09, 8'h0a, 8'h0c, 8'h0d};
    logic [15:0] ek [5] = '{16'h0000, 16'h0001, 16'h05dc, 16'h05dd, 16'hffff};
    logic [15:0] kv [3] = '{16'h4877, 16'h5e6b, 16'h4878};
    logic [1:0] ke [3] = '{2'h2, 2'h1, 2'h0};

    tcr_general_regs #(.HW_ID(HWID), .FW_PATCH(6'h15), .FW_MINOR(5'h0a), .FW_MAJOR(5'h03), .SERIAL(SER),
        .LENS_RESET(16'h0007)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .cal_busy_i(st[0]), .illum_temp_err_i(st[1]), .sensor_temp_err_i(st[2]),
        .base_temp_err_i(st[3]), .sensor_module_err_i(st[4]), .illum_overtemp_i(st[5]), .factory_map_i(st[6]),
        .calib_missing_i(st[7]), .fw_restored_i(st[8]), .poe_limited_i(st[9]), .illum_module_err_i(st[10]),
        .color_stream_err_i(st[11]), .video_mode_o(video_mode_o), .manual_trigger_o(manual_trigger_o),
        .snapshot_trigger_o(snapshot_trigger_o), .format_o(format_o), .exposure_o(exposure_o),
        .mod_freq_o(mod_freq_o), .frame_rate_o(frame_rate_o), .lens_o(lens_o), .flash_unlock_o(flash_unlock_o),
        .test_unlock_o(test_unlock_o));

    // expected exposure: writes outside 1..1500 are pulled to the nearest end
    function automatic logic [15:0] clamp_exp(input logic [15:0] x);
        return x == 16'h0000 ? 16'h0001 : (x > 16'h05dc ? 16'h05dc : x);
    endfunction
    // expected frequency: largest step of 400 from 1200 up to 4000 not above the value, 1200 for values below 1200
    function automatic logic [15:0] snap_freq(input logic [15:0] x);
        logic [15:0] f;
        f = 16'h04b0;
        while (f < 16'h0fa0 && f + 16'h0190 <= x) f = f + 16'h0190;
        return f;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bus cycles: one strobe cycle each, read data looked at in the cycle after
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e, input string nm);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(nm, e, rdata_o);
    endtask
    task automatic results();
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    // hang guard, far above the 166 accesses of the run
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        void'($urandom(32'hd44a));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values, then again after writes to read-only and unmapped places
        repeat (2) begin
            foreach (ra[i]) rd(ra[i], rv[i], "reset_value");
            foreach (ro[i]) wr(ro[i], 16'($urandom));
        end
        wr(16'h0001, 16'h0811);
        chk("trigger", 16'h0003, 16'({manual_trigger_o, snapshot_trigger_o}));
        @(posedge clk_i);
        #1;
        chk("trigger_end", 16'h0000, 16'({manual_trigger_o, snapshot_trigger_o}));
        rd(16'h0001, 16'h0001, "operating_control");
        wr(16'h0001, 16'hfffe);
        rd(16'h0001, 16'h0000, "operating_control");
        wr(16'h0001, 16'h0001);
        foreach (fc[i]) begin
            wr(16'h0004, {5'h00, fc[i], 3'h0} | (16'($urandom) & 16'hf807));
            rd(16'h0004, {5'h00, fc[i], 3'h0}, "output_format_select");
        end
        for (int i = 0; i < 12; i++) begin
            v = (i < 5) ? ek[i] : 16'($urandom % 4500);
            wr(16'h0005, v);
            rd(16'h0005, clamp_exp(v), "exposure_duration");
            wr(16'h0009, v);
            rd(16'h0009, snap_freq(v), "illum_mod_freq");
            wr(16'h000a, ~v);
            rd(16'h000a, ~v, "capture_rate");
            wr(16'h000b, v ^ 16'h5a5a);
            rd(16'h000b, v ^ 16'h5a5a, "lens_config");
        end
        // the settings outputs must carry what the last writes left behind
        chk("exposure_out", clamp_exp(v), exposure_o);
        chk("mod_freq_out", snap_freq(v), mod_freq_o);
        chk("frame_rate_out", ~v, frame_rate_o);
        chk("lens_out", v ^ 16'h5a5a, lens_o);
        chk("video_out", 16'h0001, 16'(video_mode_o));
        // all flags up, then live ones down, then a clear, then factory map gone
        @(posedge clk_i) st <= 12'hfff;
        repeat (3) @(posedge clk_i);
        rd(16'h0003, 16'hef7c, "condition_flags");
        @(posedge clk_i) st <= 12'h040;
        repeat (3) @(posedge clk_i);
        rd(16'h0003, 16'h2d60, "condition_flags");
        wr(16'h0001, 16'h0041);
        rd(16'h0003, 16'h0040, "condition_flags");
        @(posedge clk_i) st <= 12'h000;
        repeat (3) @(posedge clk_i);
        rd(16'h0003, 16'h0000, "condition_flags");
        foreach (kv[i]) begin
            wr(16'h0022, kv[i]);
            @(posedge clk_i);
            #1;
            chk("unlock", 16'(ke[i]), 16'({flash_unlock_o, test_unlock_o}));
            rd(16'h0022, kv[i], "unlock_key");
        end
        results();
    end
endmodule // tcr_general_regs_tb_top
